// *** include/e1_alarm_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the E1 alarm monitor
// Assumes: 8-bit parallel register port, 125 MHz system clock
// Notes: Definitions only
`ifndef E1_ALARM_REGS_SVH
`define E1_ALARM_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_DEVICE_IDENT 8'h0f
`define OFS_RESYNC_EVENTS 8'h12
`define OFS_RX_ALARM_STATUS 8'h18
`define OFS_RX_ALARM_MASK 8'h19
`define OFS_LINE_COND_STATUS 8'h1a
`define OFS_SYNC_SEARCH_RT 8'h30
`define OFS_E1_RX_CTRL_FIRST 8'h33
`define OFS_E1_RX_CTRL_SECOND 8'h34
`define OFS_E1_TX_CTRL_SECOND 8'h36
`define OFS_COMMON_CTRL_ONE 8'h70

// ****************************************
// Field positions and reset values
// ****************************************
`define RXC1_RESYNC 0
`define RXC1_AUTO_RESYNC_OFF 1
`define RXC1_CRC4_EN 3
`define RXC2_CL_THRESH 0
`define TXC2_AUTO_RAI 0
`define TXC2_AUTO_AIS 1
`define COMMON_CONTROL_ONE_PIN_FUNC 0
`define COMMON_CONTROL_ONE_CLK_SRC_LO 1
`define COMMON_CONTROL_ONE_CLK_SRC_HI 2
`define COMMON_CONTROL_ONE_PULSE_HALF 4
`define COMMON_CONTROL_ONE_SIG_INTEG 5
`define COMMON_CONTROL_ONE_CRC_RECALC 6
`define COMMON_CONTROL_ONE_WRITE_MASK 8'h7f
`define REG_RESET 8'h00

// ****************************************
// Detector thresholds
// ****************************************
`define CL_ZEROS_SHORT 12'd255
`define CL_ZEROS_LONG 12'd2048
`define CL_ZEROS_T1 12'd192
`define CL_CLEAR_WINDOW 8'd255
`define CL_CLEAR_ONES 8'd32
`define AIS_WINDOW 10'd512
`define AIS_MAX_ZEROS 10'd3
`define FAS_ERR_RUN 2'd3
`define CAS_ERR_RUN 2'd2
`define CRC_BLOCK_WORDS 10'd1000
`define CRC_BLOCK_ERRORS 10'd915

// ****************************************
// Timing
// ****************************************
`define CLK_SYS_KHZ 125000
`define CLK_SYS_PERIOD_PS 8000
`define CHANNEL_TIME_PS 3906250
`define CHANNEL_TIME_CYCLES ((`CHANNEL_TIME_PS + `CLK_SYS_PERIOD_PS - 1) / `CLK_SYS_PERIOD_PS)
`define CRC_SEARCH_MS 8
`define CRC_RAI_MS 128
`define CRC_ABANDON_MS 400
`define CRC_SEARCH_CYCLES (`CRC_SEARCH_MS * `CLK_SYS_KHZ)
`define CRC_RAI_TIMEOUTS (`CRC_RAI_MS / `CRC_SEARCH_MS)
`define CRC_ABANDON_TIMEOUTS (`CRC_ABANDON_MS / `CRC_SEARCH_MS)

`endif

// *** include/e1_alarm_pkg.sv ***
// Purpose: Types of the E1 alarm monitor
// Assumes: Constants live in e1_alarm_regs.svh
// Notes: None
package e1_alarm_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    TXCLK_PIN,
    TXCLK_FAILOVER,
    TXCLK_MASTER,
    TXCLK_RECOVERED
  } tx_clk_src_t;
endpackage

// *** src/e1_alarm_status_monitor.sv ***
// Purpose: E1 receive alarm and sync monitor with automatic AIS and remote alarm
// Assumes: All inputs synchronous to CLK_SYS; line bits arrive with a strobe
// Notes: Framer alignment events arrive as one-cycle pulses
`timescale 1ns/1ps
`include "e1_alarm_regs.svh"

module e1_alarm_status_monitor #(
  parameter int unsigned CRC_SEARCH_CYCLES = `CRC_SEARCH_CYCLES,
  parameter logic [3:0] DEVICE_CODE = 4'h5,  // Arbitrary value
  parameter logic [3:0] DIE_REVISION = 4'h1  // Arbitrary value
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  output logic [7:0] RD_DATA,
  output logic INT_REQ_B,
  // Line samples
  input wire logic LINE_BIT_STROBE,
  input wire logic RX_LINE_POSITIVE_IN,
  input wire logic RX_LINE_NEGATIVE_IN,
  input wire logic T1_MODE,
  input wire logic TRANSMIT_CLOCK_PIN,
  // Framer events
  input wire logic FAS_WORD_STROBE,
  input wire logic FAS_WORD_OK,
  input wire logic FAS_SYNC_FOUND,
  input wire logic CAS_WORD_STROBE,
  input wire logic CAS_WORD_OK,
  input wire logic CAS_SYNC_FOUND,
  input wire logic CRC_WORD_STROBE,
  input wire logic CRC_WORD_OK,
  input wire logic CRC_SYNC_FOUND,
  input wire logic NONALIGN_STROBE,
  input wire logic NONALIGN_BIT3,
  input wire logic MF_STROBE,
  input wire logic TS16_BIT6,
  input wire logic SA7_STROBE,
  input wire logic SA7_BIT,
  input wire logic RX_YELLOW_IN,
  // Transmit controls
  output logic TX_FORCE_AIS,
  output logic TX_REMOTE_ALARM,
  output logic SHARED_ALARM_PIN,
  output logic [1:0] TX_CLOCK_SELECT,
  output logic OUTPUT_HALF_WIDTH,
  output logic SIGNALING_INTEGRATE,
  output logic CRC_RECALCULATE
);

  // ****************************************
  // Register port
  // ****************************************
  e1_alarm_pkg::reg_byte_t e1_rx_control_first;
  e1_alarm_pkg::reg_byte_t e1_rx_control_second;
  e1_alarm_pkg::reg_byte_t e1_tx_control_second;
  e1_alarm_pkg::reg_byte_t common_control_one;
  e1_alarm_pkg::reg_byte_t receive_alarm_mask;
  e1_alarm_pkg::reg_byte_t next_rd_data;
  logic [2:0] resync_criteria_events;
  logic [3:0] clear_events;
  logic [3:0] cond_pending;
  logic [3:0] cond_prev;
  logic [3:0] cond_now;
  logic [3:0] clear_set;
  logic [5:0] crc_sync_count;
  logic receive_sync_lost;
  logic framer_carrier_lost;
  logic receive_unframed_ones;
  logic receive_remote_alarm;
  logic distant_multiframe_alarm;
  logic v52_link_detected;
  logic transmit_clock_lost;
  logic cas_mf_search_active;
  logic crc_sync;
  logic crc_abandon;
  logic resync_prev;
  logic fas_resync;
  logic cas_resync;
  logic crc_resync;
  logic rd_status2;
  logic rd_events;
  logic crc_en;

  assign rd_status2 = RD_STROBE && (ADDR == `OFS_RX_ALARM_STATUS);
  assign rd_events = RD_STROBE && (ADDR == `OFS_RESYNC_EVENTS);
  assign crc_en = e1_rx_control_first[`RXC1_CRC4_EN];

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      e1_rx_control_first <= `REG_RESET;
      e1_rx_control_second <= `REG_RESET;
      e1_tx_control_second <= `REG_RESET;
      common_control_one <= `REG_RESET;
      receive_alarm_mask <= `REG_RESET;
    end else if (WR_STROBE) begin
      case (ADDR)
        `OFS_E1_RX_CTRL_FIRST: e1_rx_control_first <= WR_DATA;
        `OFS_E1_RX_CTRL_SECOND: e1_rx_control_second <= WR_DATA;
        `OFS_E1_TX_CTRL_SECOND: e1_tx_control_second <= WR_DATA;
        `OFS_COMMON_CTRL_ONE: common_control_one <= WR_DATA & `COMMON_CONTROL_ONE_WRITE_MASK;
        `OFS_RX_ALARM_MASK: receive_alarm_mask <= WR_DATA;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ADDR)
      `OFS_DEVICE_IDENT: next_rd_data = {DEVICE_CODE, DIE_REVISION};
      `OFS_RESYNC_EVENTS: next_rd_data = {5'h00, resync_criteria_events};
      `OFS_RX_ALARM_STATUS: next_rd_data = {clear_events, cond_now};
      `OFS_RX_ALARM_MASK: next_rd_data = receive_alarm_mask;
      `OFS_LINE_COND_STATUS: next_rd_data = {3'h0, transmit_clock_lost, 1'b0,
                                             v52_link_detected, distant_multiframe_alarm,
                                             receive_remote_alarm};
      `OFS_SYNC_SEARCH_RT: next_rd_data = {crc_sync_count[5:2], crc_sync_count[0],
                                           receive_sync_lost, cas_mf_search_active,
                                           crc_en && !receive_sync_lost && !crc_sync};
      `OFS_E1_RX_CTRL_FIRST: next_rd_data = e1_rx_control_first;
      `OFS_E1_RX_CTRL_SECOND: next_rd_data = e1_rx_control_second;
      `OFS_E1_TX_CTRL_SECOND: next_rd_data = e1_tx_control_second;
      `OFS_COMMON_CTRL_ONE: next_rd_data = common_control_one;
      default: next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      RD_DATA <= 8'h00;
    end else if (RD_STROBE) begin
      RD_DATA <= next_rd_data;
    end
  end

  // ****************************************
  // Resync criteria
  // ****************************************
  logic [1:0] fas_err_run;
  logic [1:0] cas_err_run;
  logic [9:0] crc_words;
  logic [9:0] crc_errors;

  assign fas_resync = FAS_WORD_STROBE && !FAS_WORD_OK && (fas_err_run == `FAS_ERR_RUN - 2'd1);
  assign cas_resync = CAS_WORD_STROBE && !CAS_WORD_OK && (cas_err_run == `CAS_ERR_RUN - 2'd1);
  assign crc_resync = CRC_WORD_STROBE && (crc_words == `CRC_BLOCK_WORDS - 10'd1) &&
                      ((crc_errors + {9'h000, !CRC_WORD_OK}) >= `CRC_BLOCK_ERRORS);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      fas_err_run <= 2'd0;
      cas_err_run <= 2'd0;
      crc_words <= 10'd0;
      crc_errors <= 10'd0;
    end else begin
      if (FAS_WORD_STROBE) begin
        fas_err_run <= (FAS_WORD_OK || fas_resync) ? 2'd0 : fas_err_run + 2'd1;
      end
      if (CAS_WORD_STROBE) begin
        cas_err_run <= (CAS_WORD_OK || cas_resync) ? 2'd0 : cas_err_run + 2'd1;
      end
      if (CRC_WORD_STROBE) begin
        if (crc_words == `CRC_BLOCK_WORDS - 10'd1) begin
          crc_words <= 10'd0;
          crc_errors <= 10'd0;
        end else begin
          crc_words <= crc_words + 10'd1;
          crc_errors <= crc_errors + {9'h000, !CRC_WORD_OK};
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      resync_criteria_events <= 3'h0;
    end else begin
      resync_criteria_events <= (rd_events ? 3'h0 : resync_criteria_events) |
                                {crc_resync, fas_resync, cas_resync};
    end
  end

  // ****************************************
  // Synchronization state
  // ****************************************
  logic manual_resync;
  logic auto_resync;

  assign manual_resync = e1_rx_control_first[`RXC1_RESYNC] && !resync_prev;
  assign auto_resync = !e1_rx_control_first[`RXC1_AUTO_RESYNC_OFF] &&
                       (fas_resync || cas_resync || crc_resync);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      resync_prev <= 1'b0;
      receive_sync_lost <= 1'b1;
      cas_mf_search_active <= 1'b1;
      crc_sync <= 1'b0;
    end else begin
      resync_prev <= e1_rx_control_first[`RXC1_RESYNC];
      if (manual_resync || auto_resync) begin
        receive_sync_lost <= 1'b1;
      end else if (FAS_SYNC_FOUND) begin
        receive_sync_lost <= 1'b0;
      end
      if (manual_resync || auto_resync || receive_sync_lost) begin
        cas_mf_search_active <= 1'b1;
      end else if (CAS_SYNC_FOUND) begin
        cas_mf_search_active <= 1'b0;
      end
      if (!crc_en || receive_sync_lost || manual_resync || auto_resync) begin
        crc_sync <= 1'b0;
      end else if (CRC_SYNC_FOUND) begin
        crc_sync <= 1'b1;
      end
    end
  end

  // ****************************************
  // CRC4 search timing
  // ****************************************
  logic [31:0] crc_timer;
  logic crc_searching;
  logic crc_timeout;

  assign crc_searching = crc_en && !receive_sync_lost && !crc_sync;
  assign crc_timeout = crc_searching && (crc_timer == CRC_SEARCH_CYCLES - 1);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      crc_timer <= 32'd0;
      crc_sync_count <= 6'd0;
      crc_abandon <= 1'b0;
    end else if (!crc_en || crc_sync) begin
      crc_timer <= 32'd0;
      crc_sync_count <= 6'd0;
      crc_abandon <= 1'b0;
    end else if (crc_searching) begin
      crc_timer <= crc_timeout ? 32'd0 : crc_timer + 32'd1;
      if (crc_timeout) begin
        crc_sync_count <= crc_sync_count + 6'd1;
        if (crc_sync_count == 6'(`CRC_ABANDON_TIMEOUTS - 1)) begin
          crc_abandon <= 1'b1;
        end
      end
    end else begin
      crc_timer <= 32'd0;
    end
  end

  // ****************************************
  // Carrier loss
  // ****************************************
  logic mark;
  logic [11:0] zero_run;
  logic [11:0] cl_threshold;
  logic [7:0] cl_window;
  logic [7:0] cl_ones;

  assign mark = RX_LINE_POSITIVE_IN || RX_LINE_NEGATIVE_IN;
  assign cl_threshold = T1_MODE ? `CL_ZEROS_T1 :
                        (e1_rx_control_second[`RXC2_CL_THRESH] ? `CL_ZEROS_LONG :
                         `CL_ZEROS_SHORT);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      zero_run <= 12'd0;
      cl_window <= 8'd0;
      cl_ones <= 8'd0;
      framer_carrier_lost <= 1'b0;
    end else if (LINE_BIT_STROBE) begin
      zero_run <= mark ? 12'd0 : ((zero_run == cl_threshold) ? zero_run : zero_run + 12'd1);
      if (!framer_carrier_lost) begin
        cl_window <= 8'd0;
        cl_ones <= 8'd0;
        if (!mark && (zero_run == cl_threshold - 12'd1)) begin
          framer_carrier_lost <= 1'b1;
        end
      end else if (cl_window == `CL_CLEAR_WINDOW - 8'd1) begin
        cl_window <= 8'd0;
        cl_ones <= 8'd0;
        if ((cl_ones + {7'h00, mark}) >= `CL_CLEAR_ONES) begin
          framer_carrier_lost <= 1'b0;
        end
      end else begin
        cl_window <= cl_window + 8'd1;
        cl_ones <= cl_ones + {7'h00, mark};
      end
    end
  end

  // ****************************************
  // Unframed all ones
  // ****************************************
  logic [9:0] ais_window;
  logic [9:0] ais_zeros;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ais_window <= 10'd0;
      ais_zeros <= 10'd0;
      receive_unframed_ones <= 1'b0;
    end else if (LINE_BIT_STROBE) begin
      if (ais_window == `AIS_WINDOW - 10'd1) begin
        ais_window <= 10'd0;
        ais_zeros <= 10'd0;
        receive_unframed_ones <= (ais_zeros + {9'h000, !mark}) < `AIS_MAX_ZEROS;
      end else begin
        ais_window <= ais_window + 10'd1;
        ais_zeros <= ais_zeros + {9'h000, !mark};
      end
    end
  end

  // ****************************************
  // Remote, multiframe and link alarms
  // ****************************************
  logic [1:0] bit3_hist;
  logic mf_bit6_prev;
  logic [1:0] sa7_hist;
  logic [1:0] sa7_zeros;

  assign sa7_zeros = {1'b0, !SA7_BIT} + {1'b0, !sa7_hist[0]} + {1'b0, !sa7_hist[1]};

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      bit3_hist <= 2'b00;
      receive_remote_alarm <= 1'b0;
      mf_bit6_prev <= 1'b0;
      distant_multiframe_alarm <= 1'b0;
      sa7_hist <= 2'b11;
      v52_link_detected <= 1'b0;
    end else begin
      if (NONALIGN_STROBE) begin
        bit3_hist <= {bit3_hist[0], NONALIGN_BIT3};
        if (NONALIGN_BIT3 && (bit3_hist == 2'b11)) begin
          receive_remote_alarm <= 1'b1;
        end else if (!NONALIGN_BIT3 && (bit3_hist == 2'b00)) begin
          receive_remote_alarm <= 1'b0;
        end
      end
      if (MF_STROBE) begin
        mf_bit6_prev <= TS16_BIT6;
        distant_multiframe_alarm <= TS16_BIT6 && mf_bit6_prev;
      end
      if (SA7_STROBE) begin
        sa7_hist <= {sa7_hist[0], SA7_BIT};
        v52_link_detected <= sa7_zeros >= 2'd2;
      end
    end
  end

  // ****************************************
  // Transmit clock supervision
  // ****************************************
  logic [9:0] transmit_clock_pin_idle;
  logic transmit_clock_pin_prev;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      transmit_clock_pin_prev <= 1'b0;
      transmit_clock_pin_idle <= 10'd0;
      transmit_clock_lost <= 1'b0;
    end else begin
      transmit_clock_pin_prev <= TRANSMIT_CLOCK_PIN;
      if (TRANSMIT_CLOCK_PIN != transmit_clock_pin_prev) begin
        transmit_clock_pin_idle <= 10'd0;
        transmit_clock_lost <= 1'b0;
      end else if (transmit_clock_pin_idle == 10'(`CHANNEL_TIME_CYCLES - 1)) begin
        transmit_clock_lost <= 1'b1;
      end else begin
        transmit_clock_pin_idle <= transmit_clock_pin_idle + 10'd1;
      end
    end
  end

  // ****************************************
  // Status 2 events and interrupt
  // ****************************************
  assign cond_now = {RX_YELLOW_IN, receive_unframed_ones, framer_carrier_lost,
                     receive_sync_lost};
  assign clear_set = cond_prev & ~cond_now;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      cond_prev <= 4'h1;
      clear_events <= 4'h0;
      cond_pending <= 4'h0;
      INT_REQ_B <= 1'b1;
    end else begin
      cond_prev <= cond_now;
      clear_events <= (rd_status2 ? 4'h0 : clear_events) | clear_set;
      cond_pending <= (rd_status2 ? 4'h0 : cond_pending) | (cond_now & ~cond_prev);
      INT_REQ_B <= !(|({clear_events, cond_pending} & receive_alarm_mask));
    end
  end

  // ****************************************
  // Transmit alarm and control outputs
  // ****************************************
  logic rx_fault;
  logic crc_late;
  e1_alarm_pkg::tx_clk_src_t clk_src;

  assign rx_fault = receive_sync_lost || receive_unframed_ones || framer_carrier_lost;
  assign crc_late = crc_en && !crc_sync && !receive_sync_lost &&
                    ((crc_sync_count >= 6'(`CRC_RAI_TIMEOUTS)) || crc_abandon);
  assign clk_src = e1_alarm_pkg::tx_clk_src_t'({common_control_one[`COMMON_CONTROL_ONE_CLK_SRC_HI],
                                                 common_control_one[`COMMON_CONTROL_ONE_CLK_SRC_LO]});

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      TX_FORCE_AIS <= 1'b0;
      TX_REMOTE_ALARM <= 1'b0;
      SHARED_ALARM_PIN <= 1'b0;
      TX_CLOCK_SELECT <= 2'b00;
      OUTPUT_HALF_WIDTH <= 1'b0;
      SIGNALING_INTEGRATE <= 1'b0;
      CRC_RECALCULATE <= 1'b0;
    end else begin
      TX_FORCE_AIS <= e1_tx_control_second[`TXC2_AUTO_AIS] && rx_fault;
      TX_REMOTE_ALARM <= e1_tx_control_second[`TXC2_AUTO_RAI] && (rx_fault || crc_late);
      SHARED_ALARM_PIN <= common_control_one[`COMMON_CONTROL_ONE_PIN_FUNC] ? transmit_clock_lost :
                          receive_sync_lost;
      case (clk_src)
        e1_alarm_pkg::TXCLK_PIN: TX_CLOCK_SELECT <= 2'(e1_alarm_pkg::TXCLK_PIN);
        e1_alarm_pkg::TXCLK_FAILOVER: TX_CLOCK_SELECT <= transmit_clock_lost ?
          2'(e1_alarm_pkg::TXCLK_RECOVERED) : 2'(e1_alarm_pkg::TXCLK_PIN);
        e1_alarm_pkg::TXCLK_MASTER: TX_CLOCK_SELECT <= 2'(e1_alarm_pkg::TXCLK_MASTER);
        default: TX_CLOCK_SELECT <= 2'(e1_alarm_pkg::TXCLK_RECOVERED);
      endcase
      OUTPUT_HALF_WIDTH <= common_control_one[`COMMON_CONTROL_ONE_PULSE_HALF];
      SIGNALING_INTEGRATE <= common_control_one[`COMMON_CONTROL_ONE_SIG_INTEG];
      CRC_RECALCULATE <= common_control_one[`COMMON_CONTROL_ONE_CRC_RECALC] && !T1_MODE;
    end
  end

endmodule

// *** tb/e1_alarm_sva.sv ***
// Purpose: Port assertions for the E1 alarm monitor
// Assumes: Host writes tracked from the register port
// Notes: Outputs lag their register by one cycle
`timescale 1ns/1ps
module e1_alarm_sva #(
  parameter logic [3:0] DEVICE_CODE = 4'h5,
  parameter logic [3:0] DIE_REVISION = 4'h1
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [7:0] RD_DATA,
  input wire logic INT_REQ_B,
  // Transmit controls
  input wire logic TX_FORCE_AIS,
  input wire logic TX_REMOTE_ALARM,
  input wire logic SHARED_ALARM_PIN,
  input wire logic [1:0] TX_CLOCK_SELECT,
  input wire logic OUTPUT_HALF_WIDTH,
  input wire logic CRC_RECALCULATE,
  // Line mode
  input wire logic T1_MODE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ****
  // Host write shadow
  // ****
  logic [7:0] mask;
  logic ais_en;
  logic rai_en;
  logic pin_fn;
  logic rs_bit;
  logic w70;
  assign w70 = WR_STROBE && ADDR == 8'h70;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      mask <= 8'h00;
      ais_en <= 1'b0;
      rai_en <= 1'b0;
      pin_fn <= 1'b0;
      rs_bit <= 1'b0;
    end else if (WR_STROBE) begin
      if (ADDR == 8'h19) mask <= WR_DATA;
      if (ADDR == 8'h36) ais_en <= WR_DATA[1];
      if (ADDR == 8'h36) rai_en <= WR_DATA[0];
      if (ADDR == 8'h70) pin_fn <= WR_DATA[0];
      if (ADDR == 8'h33) rs_bit <= WR_DATA[0];
    end
  end
  // ****
  // Properties
  // ****
  property p_ident;
    RD_STROBE && ADDR == 8'h0f |=> RD_DATA == {DEVICE_CODE, DIE_REVISION};
  endproperty
  a_ident: assert property (p_ident) else $error("ident read wrong");
  property p_no_ais;
    !ais_en && !$past(ais_en) |-> !TX_FORCE_AIS;
  endproperty
  a_no_ais: assert property (p_no_ais) else $error("AIS while disabled");
  property p_no_rai;
    !rai_en && !$past(rai_en) |-> !TX_REMOTE_ALARM;
  endproperty
  a_no_rai: assert property (p_no_rai) else $error("RAI while disabled");
  property p_half;
    w70 |-> ##2 OUTPUT_HALF_WIDTH == $past(WR_DATA[4], 2);
  endproperty
  a_half: assert property (p_half) else $error("pulse width wrong");
  property p_recalc;
    w70 |-> ##2 CRC_RECALCULATE == ($past(WR_DATA[6], 2) && !$past(T1_MODE));
  endproperty
  a_recalc: assert property (p_recalc) else $error("recalc wrong");
  property p_clk_sel;
    w70 && WR_DATA[2:1] != 2'b01 |-> ##2 TX_CLOCK_SELECT == $past(WR_DATA[2:1], 2);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
  property p_masked;
    mask == 8'h00 && $past(mask) == 8'h00 |-> INT_REQ_B;
  endproperty
  a_masked: assert property (p_masked) else $error("masked interrupt");
  property p_resync;
    WR_STROBE && ADDR == 8'h33 && WR_DATA[0] && !rs_bit && !pin_fn
      |-> ##[1:4] SHARED_ALARM_PIN;
  endproperty
  a_resync: assert property (p_resync) else $error("no sync loss");
  c_ais: cover property (TX_FORCE_AIS);
  c_rai: cover property (TX_REMOTE_ALARM);
  c_int: cover property (!INT_REQ_B);
endmodule

// *** tb/e1_line_partner.sv ***
// Purpose: Line side model sending bits with a strobe
// Assumes: One bit every four system clocks
// Notes: Alternating pattern keeps carrier and AIS detectors quiet
`timescale 1ns/1ps
module e1_line_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pattern select
  input wire logic zeros,
  // Line bits
  output logic strobe,
  output logic pos,
  output logic neg
);
  logic [1:0] div;
  logic bit_val;
  logic pol;
  always_ff @(negedge clk) begin
    if (!rst_b) begin
      div <= 2'h0;
      strobe <= 1'b0;
      bit_val <= 1'b0;
      pol <= 1'b0;
      pos <= 1'b0;
      neg <= 1'b0;
    end else begin
      div <= div + 2'h1;
      strobe <= div == 2'h3;
      if (div == 2'h3) begin
        bit_val <= ~bit_val;
        pol <= pol ^ (~bit_val & ~zeros);
        pos <= ~bit_val & ~zeros & ~pol;
        neg <= ~bit_val & ~zeros & pol;
      end
    end
  end
endmodule

// *** tb/e1_alarm_status_monitor_tb_top.sv ***
// Purpose: Register level test of the E1 alarm monitor
// Assumes: Short CRC search period of 20 cycles
// Notes: Inputs driven on the falling edge
`timescale 1ns/1ps
module e1_alarm_status_monitor_tb_top;
  logic clk, rst_b, wr, rd, tck, tck_run, zeros, lstb, lpos, lneg, t1, yel;
  logic int_b, ais, rai, pin, half, sig, recalc;
  logic [1:0] csel;
  logic [7:0] addr, wdat, rdat;
  logic [5:0] stb, dat;
  logic [2:0] fnd;
  logic [7:0] zaddr [5] = '{8'h12, 8'h19, 8'h1a, 8'h70, 8'h40};
  logic [7:0] cw [3] = '{8'hff, 8'h04, 8'h00};
  logic [7:0] ce [3] = '{8'h1f, 8'h22, 8'h20};
  int failures, num_checks;
  e1_alarm_status_monitor #(.CRC_SEARCH_CYCLES(20)) e1_alarm_status_monitor_inst (
    .CLK_SYS(clk), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wdat), .WR_STROBE(wr),
    .RD_STROBE(rd), .RD_DATA(rdat), .INT_REQ_B(int_b), .LINE_BIT_STROBE(lstb),
    .RX_LINE_POSITIVE_IN(lpos), .RX_LINE_NEGATIVE_IN(lneg), .T1_MODE(t1),
    .TRANSMIT_CLOCK_PIN(tck), .FAS_WORD_STROBE(stb[5]), .FAS_WORD_OK(dat[5]),
    .FAS_SYNC_FOUND(fnd[2]), .CAS_WORD_STROBE(stb[4]), .CAS_WORD_OK(dat[4]),
    .CAS_SYNC_FOUND(fnd[1]), .CRC_WORD_STROBE(stb[3]), .CRC_WORD_OK(dat[3]),
    .CRC_SYNC_FOUND(fnd[0]), .NONALIGN_STROBE(stb[2]), .NONALIGN_BIT3(dat[2]),
    .MF_STROBE(stb[1]), .TS16_BIT6(dat[1]), .SA7_STROBE(stb[0]), .SA7_BIT(dat[0]),
    .RX_YELLOW_IN(yel), .TX_FORCE_AIS(ais), .TX_REMOTE_ALARM(rai),
    .SHARED_ALARM_PIN(pin), .TX_CLOCK_SELECT(csel), .OUTPUT_HALF_WIDTH(half),
    .SIGNALING_INTEGRATE(sig), .CRC_RECALCULATE(recalc));
  e1_line_partner e1_line_partner_inst (.clk(clk), .rst_b(rst_b), .zeros(zeros),
    .strobe(lstb), .pos(lpos), .neg(lneg));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) if (tck_run) tck <= ~tck;
  // ****
  // Tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(n, e, rdat & m);
  endtask
  task automatic pulse(input logic [5:0] s, input logic [5:0] d, input int n);
    repeat (n) begin
      @(negedge clk);
      stb = s;
      dat = d;
      @(negedge clk);
      stb = 6'h00;
    end
  endtask
  task automatic found(input logic [2:0] f);
    @(negedge clk);
    fnd = f & 3'h4;
    @(negedge clk);
    fnd = f & 3'h3;
    @(negedge clk);
    fnd = 3'h0;
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // ****
  // Tests
  // ****
  initial begin
    {rst_b, wr, rd, tck, zeros, t1, yel, addr, wdat, stb, dat, fnd} = '0;
    tck_run = 1'b1;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rc("ident", 8'h0f, 8'h51, 8'hff);
    rc("status", 8'h18, 8'h01, 8'hff);
    rc("search", 8'h30, 8'h06, 8'hff);
    foreach (zaddr[i]) rc("zero", zaddr[i], 8'h00, 8'hff);
    chk("int", 8'h01, {7'h0, int_b});
    wr_reg(8'h0f, 8'h00);
    rc("ident", 8'h0f, 8'h51, 8'hff);
    wr_reg(8'h19, 8'ha5);
    rc("mask", 8'h19, 8'ha5, 8'hff);
    wr_reg(8'h19, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h70, cw[i]);
      rc("common_control_one", 8'h70, cw[i] & 8'h7f, 8'hff);
      chk("ctl", ce[i], {2'h0, pin, half, sig, recalc, csel});
    end
    $display("done reset and control");
    wr_reg(8'h36, 8'h02);
    waitc(3);
    chk("ais", 8'h01, {7'h0, ais});
    found(3'h6);
    waitc(3);
    chk("ais", 8'h00, {7'h0, ais});
    rc("status", 8'h18, 8'h10, 8'hff);
    rc("status", 8'h18, 8'h00, 8'hff);
    rc("search", 8'h30, 8'h00, 8'h06);
    pulse(6'h10, 6'h00, 2);
    rc("events", 8'h12, 8'h01, 8'hff);
    found(3'h6);
    pulse(6'h20, 6'h00, 3);
    rc("events", 8'h12, 8'h02, 8'hff);
    rc("events", 8'h12, 8'h00, 8'hff);
    rc("status", 8'h18, 8'h01, 8'h01);
    found(3'h6);
    rc("status", 8'h18, 8'h10, 8'h10);
    $display("done sync");
    wr_reg(8'h34, 8'h01);
    zeros = 1'b1;
    waitc(1100);
    rc("status", 8'h18, 8'h00, 8'h02);
    waitc(7400);
    rc("status", 8'h18, 8'h02, 8'h02);
    chk("ais", 8'h01, {7'h0, ais});
    zeros = 1'b0;
    waitc(2200);
    rc("status", 8'h18, 8'h20, 8'h22);
    wr_reg(8'h34, 8'h00);
    wr_reg(8'h19, 8'h02);
    zeros = 1'b1;
    waitc(1100);
    chk("int", 8'h00, {7'h0, int_b});
    rc("status", 8'h18, 8'h02, 8'h02);
    waitc(2);
    chk("int", 8'h01, {7'h0, int_b});
    zeros = 1'b0;
    waitc(2200);
    wr_reg(8'h19, 8'h00);
    rc("status", 8'h18, 8'h20, 8'h22);
    $display("done carrier");
    pulse(6'h07, 6'h06, 3);
    rc("line", 8'h1a, 8'h07, 8'h07);
    wr_reg(8'h70, 8'h03);
    tck_run = 1'b0;
    waitc(600);
    chk("clk", 8'h07, {5'h0, pin, csel});
    rc("line", 8'h1a, 8'h10, 8'h10);
    tck_run = 1'b1;
    wr_reg(8'h70, 8'h00);
    $display("done line");
    wr_reg(8'h36, 8'h00);
    wr_reg(8'h36, 8'h01);
    wr_reg(8'h33, 8'h08);
    waitc(1100);
    chk("rai", 8'h01, {7'h0, rai});
    rc("count", 8'h30, 8'hd9, 8'hf9);
    found(3'h1);
    waitc(3);
    chk("rai", 8'h00, {7'h0, rai});
    rc("search", 8'h30, 8'h00, 8'hf9);
    wr_reg(8'h33, 8'h01);
    rc("status", 8'h18, 8'h01, 8'h01);
    chk("rai", 8'h01, {7'h0, rai});
    wr_reg(8'h36, 8'h00);
    $display("done crc and resync");
    wr_reg(8'h70, 8'h40);
    t1 = 1'b1;
    yel = 1'b1;
    zeros = 1'b1;
    waitc(850);
    chk("recalc", 8'h00, {7'h0, recalc});
    rc("status", 8'h18, 8'h0a, 8'h0a);
    yel = 1'b0;
    rc("status", 8'h18, 8'h80, 8'h88);
    $display("done t1");
    print_verdict();
  end
endmodule
bind e1_alarm_status_monitor e1_alarm_sva #(.DEVICE_CODE(DEVICE_CODE),
  .DIE_REVISION(DIE_REVISION)) e1_alarm_sva_inst (.*);
